// File: src/ssl_buf.sv
/*
 * One-word buffer with flush, honest full and empty flags.
 * Assumes push and pop come from core_clk logic.
 */
`timescale 1ns/100ps
module ssl_buf #(
    parameter int W = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push,
    input wire logic [W-1:0] push_data,
    input wire logic pop,
    output logic [W-1:0] data,
    output logic full,
    output logic empty
);
    logic held_q;
    logic [W-1:0] word_q;

    assign data = word_q;
    assign full = held_q;
    assign empty = !held_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            held_q <= 1'b0;
            word_q <= '0;
        end else if (flush) begin
            held_q <= 1'b0;
            word_q <= '0;
        end else if (push && (!held_q || pop)) begin
            held_q <= 1'b1;
            word_q <= push_data;
        end else if (pop) begin
            held_q <= 1'b0;
        end
    end
endmodule // ssl_buf

// File: src/ssl_defs.svh
/*
 * Register offsets, field positions, reset values and codes of the serial
 * line buffer controller.
 * Assumes it is included by bare name by every file that needs a constant.
 */
`ifndef SSL_DEFS_SVH
`define SSL_DEFS_SVH

`define SSL_OFS_CTL 8'h00
`define SSL_OFS_CTLIN 8'h20
`define SSL_OFS_CLKIN 8'h28
`define SSL_OFS_LINE 8'h2c
`define SSL_OFS_TX 8'h30
`define SSL_OFS_RX 8'h34
`define SSL_OFS_BUFCTL 8'h38
`define SSL_OFS_BUFSTS 8'h3c
`define SSL_OFS_PROT 8'h5c

`define SSL_B_IN_INV 2
`define SSL_B_RESYNC 0
`define SSL_B_LSB 0
`define SSL_B_DAT_INV 5
`define SSL_B_SEL_INV 7
`define SSL_F_WL_HI 11
`define SSL_F_WL_LO 8
`define SSL_B_DIR 16
`define SSL_B_RX_RST 17
`define SSL_B_TX_RST 16
`define SSL_B_RX_CLR 15
`define SSL_B_RX_OV_IE 14
`define SSL_B_TX_CLR 7
`define SSL_B_TX_UD_IE 6
`define SSL_B_TX_UD_F 11
`define SSL_B_TX_FULL 9
`define SSL_B_TX_EMPTY 8
`define SSL_B_RX_OV_F 3
`define SSL_B_RX_FULL 1
`define SSL_B_RX_EMPTY 0
`define SSL_F_PROTO_HI 2
`define SSL_F_PROTO_LO 0
`define SSL_F_MODE_HI 14
`define SSL_F_MODE_LO 12
`define SSL_B_UD_LVL 28

`define SSL_STS_RESET 32'h0000_0101
`define SSL_PROTO_OFF 3'h0
`define SSL_PROTO_SPI 3'h1
`define SSL_MODE_FULL 3'h0
`define SSL_MODE_HALF 3'h4
`define SSL_WL_MIN 4'h4
`define SSL_WL_MAX 5'h10
`define SSL_TX_W 17
`define SSL_RX_W 16

`endif

// File: src/ssl_line_ctrl.sv
/*
 * SPI slave line conditioning, word framing and buffer control with a
 * plain register port.
 * Assumes select, clock and data pins are asynchronous to core_clk and the
 * clock runs in mode 0: sample on rising edge, shift on falling edge.
 */
`timescale 1ns/100ps
`include "ssl_defs.svh"
module ssl_line_ctrl (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire ssl_pkg::ssl_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output ssl_pkg::ssl_word_t reg_rdata,
    input wire logic sel_pin,
    input wire logic sclk_pin,
    input wire logic dat0_i,
    input wire logic dat1_i,
    output logic dat0_o,
    output logic dat0_oe,
    output logic sel_out,
    output logic irq
);
    import ssl_pkg::*;

    function automatic ssl_len_t word_len(input logic [3:0] code);
        if (code < `SSL_WL_MIN)
            return `SSL_WL_MAX;
        return {1'b0, code};
    endfunction

    function automatic logic [3:0] bit_pos(input ssl_len_t cnt,
                                           input ssl_len_t len,
                                           input logic lsb);
        ssl_len_t t;
        t = len - 5'd1 - cnt;
        return lsb ? cnt[3:0] : t[3:0];
    endfunction

    logic in_inv_q, in_resync_q, clk_resync_q, lsb_q;
    logic data_output_invert_q, select_output_invert_q;
    logic [3:0] word_length_q;
    logic [2:0] protocol_select_q, shift_mode_select_q;
    logic underrun_output_level_q;
    logic rx_ov_ie_q, tx_ud_ie_q, tx_ud_flag_q, rx_ov_flag_q;
    logic rx_rst_p_q, tx_rst_p_q, rx_clr_p_q, tx_clr_p_q;
    ssl_word_t reg_rdata_q;
    logic dat0_o_q, dat0_oe_q, sel_out_q, irq_q;

    wire wr_ctl = reg_wr && reg_addr == `SSL_OFS_CTL;
    wire wr_ctlin = reg_wr && reg_addr == `SSL_OFS_CTLIN;
    wire wr_clkin = reg_wr && reg_addr == `SSL_OFS_CLKIN;
    wire wr_line = reg_wr && reg_addr == `SSL_OFS_LINE;
    wire wr_tx = reg_wr && reg_addr == `SSL_OFS_TX;
    wire wr_bufctl = reg_wr && reg_addr == `SSL_OFS_BUFCTL;
    wire wr_sts = reg_wr && reg_addr == `SSL_OFS_BUFSTS;
    wire wr_prot = reg_wr && reg_addr == `SSL_OFS_PROT;
    wire rd_rx = reg_rd && reg_addr == `SSL_OFS_RX;
    wire mode_chg = wr_prot && reg_wdata[`SSL_F_MODE_HI:`SSL_F_MODE_LO]
                    != shift_mode_select_q;

    wire spi_on = protocol_select_q == `SSL_PROTO_SPI;
    wire half = shift_mode_select_q == `SSL_MODE_HALF;
    ssl_len_t len;
    assign len = word_len(word_length_q);

    // Reserved bits are simply not stored, so they read back as zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_inv_q <= 1'b0;
            in_resync_q <= 1'b0;
            clk_resync_q <= 1'b0;
            lsb_q <= 1'b0;
            word_length_q <= 4'h0;
            data_output_invert_q <= 1'b0;
            select_output_invert_q <= 1'b0;
            protocol_select_q <= `SSL_PROTO_OFF;
            shift_mode_select_q <= `SSL_MODE_FULL;
            underrun_output_level_q <= 1'b0;
            rx_ov_ie_q <= 1'b0;
            tx_ud_ie_q <= 1'b0;
        end else begin
            if (wr_ctl)
                protocol_select_q <=
                    reg_wdata[`SSL_F_PROTO_HI:`SSL_F_PROTO_LO];
            if (wr_ctlin) begin
                in_inv_q <= reg_wdata[`SSL_B_IN_INV];
                in_resync_q <= reg_wdata[`SSL_B_RESYNC];
            end
            if (wr_clkin)
                clk_resync_q <= reg_wdata[`SSL_B_RESYNC];
            if (wr_line) begin
                lsb_q <= reg_wdata[`SSL_B_LSB];
                word_length_q <= reg_wdata[`SSL_F_WL_HI:`SSL_F_WL_LO];
                data_output_invert_q <= reg_wdata[`SSL_B_DAT_INV];
                select_output_invert_q <= reg_wdata[`SSL_B_SEL_INV];
            end
            if (wr_bufctl) begin
                rx_ov_ie_q <= reg_wdata[`SSL_B_RX_OV_IE];
                tx_ud_ie_q <= reg_wdata[`SSL_B_TX_UD_IE];
            end
            if (wr_prot) begin
                shift_mode_select_q <=
                    reg_wdata[`SSL_F_MODE_HI:`SSL_F_MODE_LO];
                underrun_output_level_q <= reg_wdata[`SSL_B_UD_LVL];
            end
        end
    end

    // One-cycle action pulses; the stored bits always read as zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_rst_p_q <= 1'b0;
            tx_rst_p_q <= 1'b0;
            rx_clr_p_q <= 1'b0;
            tx_clr_p_q <= 1'b0;
        end else begin
            rx_rst_p_q <= (wr_bufctl && reg_wdata[`SSL_B_RX_RST])
                          || mode_chg;
            tx_rst_p_q <= (wr_bufctl && reg_wdata[`SSL_B_TX_RST])
                          || mode_chg;
            rx_clr_p_q <= wr_bufctl && reg_wdata[`SSL_B_RX_CLR];
            tx_clr_p_q <= wr_bufctl && reg_wdata[`SSL_B_TX_CLR];
        end
    end

    // Pin conditioning. The invert gate sits ahead of the first flop.
    logic sel_s, sclk_s, dat0_s, dat1_s;
    logic sel_prev_q, sel_filt_q, sclk_prev_q, sclk_filt_q, sclk_d_q;
    wire sel_raw = sel_pin ^ in_inv_q;

    ssl_sync2 u_sync_sel (.core_clk(core_clk), .rst_n(rst_n),
        .d(sel_raw), .q(sel_s));
    ssl_sync2 u_sync_sclk (.core_clk(core_clk), .rst_n(rst_n),
        .d(sclk_pin), .q(sclk_s));
    ssl_sync2 u_sync_d0 (.core_clk(core_clk), .rst_n(rst_n),
        .d(dat0_i), .q(dat0_s));
    ssl_sync2 u_sync_d1 (.core_clk(core_clk), .rst_n(rst_n),
        .d(dat1_i), .q(dat1_s));

    // The filtered path only follows a level seen on two samples in a row,
    // trading two cycles of latency for glitch rejection.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_prev_q <= 1'b0;
            sel_filt_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            sclk_filt_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_s;
            sclk_prev_q <= sclk_s;
            if (sel_s == sel_prev_q)
                sel_filt_q <= sel_s;
            if (sclk_s == sclk_prev_q)
                sclk_filt_q <= sclk_s;
        end
    end

    wire sel_use = in_resync_q ? sel_filt_q : sel_s;
    wire sclk_use = clk_resync_q ? sclk_filt_q : sclk_s;
    wire sel_int = sel_use && spi_on;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            sclk_d_q <= 1'b0;
        else
            sclk_d_q <= sclk_use;
    end

    wire rise = sclk_use && !sclk_d_q;
    wire fall = !sclk_use && sclk_d_q;

    // Buffers.
    logic [`SSL_TX_W-1:0] tx_buf_data;
    logic [`SSL_RX_W-1:0] rx_buf_data, rx_next;
    logic tx_full, tx_empty, rx_full, rx_empty;
    logic tx_pop, rx_push;

    ssl_buf #(.W(`SSL_TX_W)) u_tx_buf (
        .core_clk(core_clk), .rst_n(rst_n),
        .flush(tx_rst_p_q || tx_clr_p_q),
        .push(wr_tx),
        .push_data(reg_wdata[`SSL_TX_W-1:0]),
        .pop(tx_pop), .data(tx_buf_data), .full(tx_full),
        .empty(tx_empty));

    ssl_buf #(.W(`SSL_RX_W)) u_rx_buf (
        .core_clk(core_clk), .rst_n(rst_n),
        .flush(rx_rst_p_q || rx_clr_p_q),
        .push(rx_push), .push_data(rx_next), .pop(rd_rx),
        .data(rx_buf_data), .full(rx_full), .empty(rx_empty));

    // Shift engine.
    ssl_state_t state_q;
    ssl_len_t cnt_q;
    logic load_pend_q, first_q, underrun_q, tx_dir_q, tx_bit_q;
    logic [`SSL_RX_W-1:0] tx_sh_q, rx_sh_q;
    wire path_rst = tx_rst_p_q || rx_rst_p_q;
    wire active = state_q == SSL_SHIFT && sel_int;
    wire load_now = active && load_pend_q && (first_q || fall);
    wire last_bit = cnt_q == len - 5'd1;
    wire rx_bit = half ? dat0_s : dat1_s;

    assign tx_pop = load_now && !tx_empty;
    assign rx_push = active && rise && last_bit;

    always_comb begin
        rx_next = rx_sh_q;
        rx_next[bit_pos(cnt_q, len, lsb_q)] = rx_bit;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SSL_IDLE;
            cnt_q <= 5'd0;
            load_pend_q <= 1'b0;
            first_q <= 1'b0;
        end else if (path_rst || !sel_int) begin
            state_q <= SSL_IDLE;
            cnt_q <= 5'd0;
            load_pend_q <= 1'b0;
            first_q <= 1'b0;
        end else begin
            case (state_q)
                SSL_IDLE: begin
                    state_q <= SSL_SHIFT;
                    load_pend_q <= 1'b1;
                    first_q <= 1'b1;
                end
                SSL_SHIFT: begin
                    if (load_now) begin
                        load_pend_q <= 1'b0;
                        first_q <= 1'b0;
                    end
                    if (rise) begin
                        cnt_q <= last_bit ? 5'd0 : cnt_q + 5'd1;
                        if (last_bit)
                            load_pend_q <= 1'b1;
                    end
                end
                default: state_q <= SSL_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_q <= '0;
            tx_bit_q <= 1'b0;
            tx_dir_q <= 1'b0;
            underrun_q <= 1'b0;
        end else if (tx_rst_p_q) begin
            tx_sh_q <= '0;
            tx_bit_q <= 1'b0;
            tx_dir_q <= 1'b0;
            underrun_q <= 1'b0;
        end else if (!active) begin
            underrun_q <= 1'b0;
        end else if (load_now) begin
            underrun_q <= tx_empty;
            if (!tx_empty) begin
                tx_sh_q <= tx_buf_data[`SSL_RX_W-1:0];
                tx_dir_q <= tx_buf_data[`SSL_B_DIR];
                tx_bit_q <= tx_buf_data[bit_pos(5'd0, len, lsb_q)];
            end
        end else if (fall && !load_pend_q) begin
            tx_bit_q <= tx_sh_q[bit_pos(cnt_q, len, lsb_q)];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            rx_sh_q <= '0;
        else if (rx_rst_p_q || !active)
            rx_sh_q <= '0;
        else if (rise)
            rx_sh_q <= last_bit ? '0 : rx_next;
    end

    // Sticky flags: a new event in the clearing cycle wins.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ud_flag_q <= 1'b0;
            rx_ov_flag_q <= 1'b0;
        end else begin
            if (load_now && tx_empty)
                tx_ud_flag_q <= 1'b1;
            else if (wr_sts && reg_wdata[`SSL_B_TX_UD_F])
                tx_ud_flag_q <= 1'b0;
            if (rx_push && rx_full && !rd_rx)
                rx_ov_flag_q <= 1'b1;
            else if (wr_sts && reg_wdata[`SSL_B_RX_OV_F])
                rx_ov_flag_q <= 1'b0;
        end
    end

    // Pins and request line, all straight from flops.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dat0_o_q <= 1'b0;
            dat0_oe_q <= 1'b0;
            sel_out_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (tx_rst_p_q && !data_output_invert_q)
                dat0_o_q <= 1'b0;
            else if (underrun_q)
                dat0_o_q <= underrun_output_level_q;
            else
                dat0_o_q <= tx_bit_q ^ data_output_invert_q;
            dat0_oe_q <= spi_on && !(half && tx_dir_q);
            sel_out_q <= sel_int ^ select_output_invert_q;
            irq_q <= (tx_ud_flag_q && tx_ud_ie_q)
                     || (rx_ov_flag_q && rx_ov_ie_q);
        end
    end

    // Read port: data stand in the cycle after the strobe. A read of the
    // receive word also frees the buffer.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= '0;
        end else if (reg_rd) begin
            reg_rdata_q <= '0;
            case (reg_addr)
                `SSL_OFS_CTL: reg_rdata_q[2:0] <= protocol_select_q;
                `SSL_OFS_CTLIN: begin
                    reg_rdata_q[`SSL_B_IN_INV] <= in_inv_q;
                    reg_rdata_q[`SSL_B_RESYNC] <= in_resync_q;
                end
                `SSL_OFS_CLKIN: reg_rdata_q[`SSL_B_RESYNC] <= clk_resync_q;
                `SSL_OFS_LINE: begin
                    reg_rdata_q[`SSL_B_LSB] <= lsb_q;
                    reg_rdata_q[`SSL_F_WL_HI:`SSL_F_WL_LO] <= word_length_q;
                    reg_rdata_q[`SSL_B_DAT_INV] <= data_output_invert_q;
                    reg_rdata_q[`SSL_B_SEL_INV] <= select_output_invert_q;
                end
                `SSL_OFS_RX: reg_rdata_q[15:0] <= rx_buf_data;
                `SSL_OFS_BUFCTL: begin
                    reg_rdata_q[`SSL_B_RX_OV_IE] <= rx_ov_ie_q;
                    reg_rdata_q[`SSL_B_TX_UD_IE] <= tx_ud_ie_q;
                end
                `SSL_OFS_BUFSTS: begin
                    reg_rdata_q[`SSL_B_TX_UD_F] <= tx_ud_flag_q;
                    reg_rdata_q[`SSL_B_TX_FULL] <= tx_full;
                    reg_rdata_q[`SSL_B_TX_EMPTY] <= tx_empty;
                    reg_rdata_q[`SSL_B_RX_OV_F] <= rx_ov_flag_q;
                    reg_rdata_q[`SSL_B_RX_FULL] <= rx_full;
                    reg_rdata_q[`SSL_B_RX_EMPTY] <= rx_empty;
                end
                `SSL_OFS_PROT: begin
                    reg_rdata_q[`SSL_F_MODE_HI:`SSL_F_MODE_LO] <=
                        shift_mode_select_q;
                    reg_rdata_q[`SSL_B_UD_LVL] <= underrun_output_level_q;
                end
                default: reg_rdata_q <= '0;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign dat0_o = dat0_o_q;
    assign dat0_oe = dat0_oe_q;
    assign sel_out = sel_out_q;
    assign irq = irq_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence seq_bufctl_bit(int b);
        wr_bufctl && reg_wdata[b];
    endsequence

    AST_RX_RST_PULSE: assert property (
        seq_bufctl_bit(`SSL_B_RX_RST) |=> rx_rst_p_q ##1 !rx_rst_p_q
                                           && rx_empty)
        else $error("receive reset not a one-cycle pulse");
    AST_TX_RST_EMPTY: assert property (
        seq_bufctl_bit(`SSL_B_TX_RST) ##1 1'b1 |=> tx_empty && !tx_full)
        else $error("transmit reset left buffer full");
    AST_TX_RST_PIN: assert property (
        tx_rst_p_q && !data_output_invert_q |=> !dat0_o_q)
        else $error("data pin not low after transmit reset");
    AST_RX_FLUSH: assert property (
        seq_bufctl_bit(`SSL_B_RX_CLR) ##1 1'b1 |=> rx_empty)
        else $error("receive flush left data");
    AST_TX_FLUSH: assert property (
        seq_bufctl_bit(`SSL_B_TX_CLR) ##1 1'b1 |=> tx_empty)
        else $error("transmit flush left data");
    AST_OVR_KEEP: assert property (
        rx_push && rx_full && !rd_rx && !rx_rst_p_q && !rx_clr_p_q
        |=> rx_ov_flag_q && $stable(rx_buf_data))
        else $error("overrun changed buffered word");
    AST_UDR_LEVEL: assert property (
        underrun_q && !tx_rst_p_q
        |=> dat0_o_q == $past(underrun_output_level_q))
        else $error("under-run level wrong");
    AST_MODE_RST: assert property (
        mode_chg |=> tx_rst_p_q && rx_rst_p_q ##1 tx_empty && rx_empty)
        else $error("mode change did not reset paths");
    AST_TX_LATCH: assert property (
        wr_tx && tx_empty && !tx_rst_p_q && !tx_clr_p_q && !tx_pop
        |=> tx_full && tx_buf_data == $past(reg_wdata[16:0]))
        else $error("transmit word and direction not latched");
    AST_IRQ: assert property (
        rx_ov_flag_q && rx_ov_ie_q |=> irq_q)
        else $error("overrun request missing");
endmodule // ssl_line_ctrl

// File: src/ssl_pkg.sv
/*
 * Types shared by the serial line buffer controller.
 * Assumes the constants header is compiled alongside.
 */
package ssl_pkg;
    typedef enum logic [0:0] {SSL_IDLE, SSL_SHIFT} ssl_state_t;
    typedef logic [4:0] ssl_len_t;
    typedef logic [31:0] ssl_word_t;
endpackage

// File: src/ssl_sync2.sv
/*
 * Two-flop synchroniser for one pin level.
 * Assumes the input is asynchronous to core_clk.
 */
`timescale 1ns/100ps
module ssl_sync2 (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // ssl_sync2

// File: tb/ssl_spi_master.sv
/*
 * Mode 0 SPI master model that drives select, clock and the slave's data in.
 * Assumes the slave samples on rising and shifts on falling clock edges.
 */
`timescale 1ns/100ps
module ssl_spi_master (
    output logic sel_pin,
    output logic sclk_pin,
    output logic dat1_i,
    input wire logic dat0_o
);
    initial begin
        sel_pin = 1'b0;
        sclk_pin = 1'b0;
        dat1_i = 1'b0;
    end
    // The clock stands low outside frames; it never runs free.
    task automatic xfer(input logic [15:0] mosi, input int n,
                        output logic [15:0] miso);
        miso = 16'h0000;
        #2 sel_pin = 1'b1;
        #80;
        for (int i = n - 1; i >= 0; i--) begin
            dat1_i = mosi[i];
            #40 sclk_pin = 1'b1;
            miso = {miso[14:0], dat0_o};
            #40 sclk_pin = 1'b0;
        end
        #40 sel_pin = 1'b0;
        // A released line must not keep showing the last bit.
        dat1_i = ~dat1_i;
    endtask
endmodule // ssl_spi_master

// File: tb/tb.sv
/*
 * Register-level bench for the serial line buffer controller.
 * Assumes a mode 0 master model on the pins and a one-cycle read port.
 */
`timescale 1ns/100ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
    fail_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
    import ssl_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    ssl_word_t reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    ssl_word_t reg_rdata, d;
    logic sel_pin, sclk_pin, dat1_i, dat0_o, dat0_oe, sel_out, irq;
    logic [15:0] m;
    int fail_count = 0;
    int tests_run = 0;
    initial forever #4 core_clk = ~core_clk;
    ssl_line_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sel_pin(sel_pin),
        .sclk_pin(sclk_pin), .dat0_i(dat1_i), .dat1_i(dat1_i),
        .dat0_o(dat0_o), .dat0_oe(dat0_oe), .sel_out(sel_out), .irq(irq));
    ssl_spi_master M (.sel_pin(sel_pin), .sclk_pin(sclk_pin),
        .dat1_i(dat1_i), .dat0_o(dat0_o));
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input ssl_word_t v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output ssl_word_t v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        finish_test();
    end
    initial begin
        wt(5);
        rst_n <= 1'b1;
        rd(8'h3c, d); `CHK("status reset", 32'h0000_0101, d)
        rd(8'h10, d); `CHK("unmapped", 32'h0, d)
        wr(8'h00, 32'h1);
        wr(8'h2c, 32'h0);
        wr(8'h30, 32'h0000_a5c3);
        rd(8'h3c, d); `CHK("tx full", 32'h0000_0201, d)
        M.xfer(16'h1234, 16, m); wt(10);
        `CHK("miso msb 16", 16'ha5c3, m)
        // The closing clock fall opens a next word, which finds no data.
        rd(8'h3c, d); `CHK("rx full", 32'h0000_0902, d)
        rd(8'h34, d); `CHK("rx word", 32'h0000_1234, d)
        // Eight bits, LSB first, inverted: 0x1c goes out as 0xc7 MSB-wise.
        wr(8'h2c, 32'h0000_0821);
        wr(8'h30, 32'h0000_001c);
        M.xfer(16'h000f, 8, m); wt(10);
        `CHK("miso lsb inv", 16'h00c7, m)
        rd(8'h34, d); `CHK("rx right aligned", 32'h0000_00f0, d)
        // No word queued: the line shows the chosen under-run level.
        wr(8'h2c, 32'h0);
        wr(8'h5c, 32'h1000_0000);
        wr(8'h3c, 32'h0000_0800);
        wr(8'h38, 32'h0000_0040); wt(2);
        `CHK("irq idle", 1'b0, irq)
        M.xfer(16'h0000, 16, m); wt(10);
        `CHK("underrun level", 16'hffff, m)
        `CHK("irq underrun", 1'b1, irq)
        rd(8'h3c, d); `CHK("underrun flag", 32'h0000_0902, d)
        wr(8'h38, 32'h0001_0040); wt(3);
        `CHK("tx reset pin", 1'b0, dat0_o)
        rd(8'h38, d); `CHK("tx reset clears", 32'h0000_0040, d)
        wr(8'h3c, 32'h0000_0800); wt(2);
        `CHK("irq cleared", 1'b0, irq)
        // A second word into a full buffer must not replace the first.
        M.xfer(16'hbeef, 16, m); wt(10);
        rd(8'h3c, d); `CHK("overrun", 32'h0000_090a, d)
        rd(8'h34, d); `CHK("rx kept", 32'h0, d)
        M.xfer(16'h00aa, 16, m); wt(10);
        wr(8'h3c, 32'h0000_0808);
        wr(8'h38, 32'h0002_0000); wt(2);
        rd(8'h3c, d); `CHK("rx reset", 32'h0000_0101, d)
        M.xfer(16'h0055, 16, m); wt(10);
        wr(8'h3c, 32'h0000_0800);
        wr(8'h38, 32'h0000_8000); wt(2);
        rd(8'h3c, d); `CHK("rx flush", 32'h0000_0101, d)
        wr(8'h30, 32'h0000_0055);
        wr(8'h38, 32'h0000_0080);
        rd(8'h3c, d); `CHK("tx flush", 32'h0000_0101, d)
        wr(8'h30, 32'h0000_0066);
        wr(8'h5c, 32'h0000_4000); wt(2);
        rd(8'h3c, d); `CHK("mode reset", 32'h0000_0101, d)
        `CHK("half dir out", 1'b1, dat0_oe)
        wr(8'h30, 32'h0001_5a5a);
        M.xfer(16'h3c3c, 16, m); wt(10);
        `CHK("half dir in", 1'b0, dat0_oe)
        rd(8'h34, d); `CHK("half rx", 32'h0000_3c3c, d)
        wr(8'h5c, 32'h0);
        wr(8'h2c, 32'h0000_0080); wt(4);
        `CHK("sel out inv", 1'b1, sel_out)
        wr(8'h2c, 32'h0); wt(4);
        `CHK("sel out", 1'b0, sel_out)
        wr(8'h28, 32'hffff_ffff);
        rd(8'h28, d); `CHK("clock cfg", 32'h1, d)
        wr(8'h20, 32'hffff_ffff); wt(6);
        rd(8'h20, d); `CHK("ctl cfg", 32'h5, d)
        `CHK("sel in inv", 1'b1, sel_out)
        finish_test();
    end
endmodule // tb
